// [core/hif_consts.svh]
// Offsets, field positions, reset and start-up values of the result block
`ifndef HIF_CONSTS_SVH
`define HIF_CONSTS_SVH

// ****************************************
// Device register offsets
// ****************************************
`define HIF_A_EVENTS      8'h11
`define HIF_A_MAG_FLAGS   8'h16
`define HIF_A_MAG_AMP_LO  8'h17
`define HIF_A_MAG_AMP_HI  8'h18
`define HIF_A_CHAN2_MODE  8'h42
`define HIF_A_CHAN2_SENSE 8'h45
`define HIF_A_CHAN2_TUNE  8'h48
`define HIF_A_CHAN2_EXTRA 8'h4B
`define HIF_A_UI_ENABLE   8'h50
`define HIF_A_HYST_CFG    8'h80
`define HIF_A_HALT_THR    8'h81
`define HIF_A_NEAR_THR    8'h82
`define HIF_A_CONTACT_THR 8'h83

// ****************************************
// Field positions
// ****************************************
`define HIF_EV_BUTTON     0
`define HIF_EV_ABS_UI     1
`define HIF_EV_MAGNET     2
`define HIF_EV_DUAL_UI    3
`define HIF_EV_THERMAL    4
`define HIF_EV_CHIP       5
`define HIF_EV_POWER      6
`define HIF_EV_GUARD      7
`define HIF_UI_HYST_EN    0
`define HIF_UI_ABS_SEL    1

// ****************************************
// Reset values
// ****************************************
`define HIF_RST_BYTE      8'h00

// ****************************************
// Host start-up values for channel 2
// ****************************************
`define HIF_INIT_MODE     8'h0E
`define HIF_INIT_SENSE    8'h03
`define HIF_INIT_TUNE     8'h82
`define HIF_INIT_UI       8'h01
`define HIF_INIT_STEPS    3'h4

// ****************************************
// Host APB register offsets
// ****************************************
`define HIF_APB_CMD       12'h000
`define HIF_APB_STATUS    12'h004

`endif

// [core/hif_device.sv]
// Sensor device end: magnet and inductive result registers
`timescale 1ns/1ps
`include "hif_consts.svh"
`default_nettype none
// How it works
// - Magnet detection toggles event bit two
// - Event register read-only, eight flags, host polls
// - Magnet flags hold near and close levels
// - Magnet flags bit zero shows polarity
// - Amplitude 16 bits, low then high byte
// - Channels zero to two may sense inductively
// - Dual-level interface fed by channel two only
// - Separate thresholds, own hysteresis, filter halt
// - Host sets channel two inductive, both inputs
// - Button and absorption interfaces exclusive
// - Host never writes inactive interface settings
// - Dual-level interface runs beside either other
// - Dual-level interface runs only when enabled
// - Programmable threshold halts channel two filter
// - Channel two compared with near, contact thresholds
// - Hysteresis applied to both level outputs
// - Host sets tuning target above base
// - Host selects full auto tuning
// - Channels four, five give differential magnet input
module hif_device (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Register link
  hif_link_if.device       link,
  // Magnet front end, channels four and five
  input  wire logic        hall_valid,
  input  wire logic [15:0] hall_pos_data,
  input  wire logic [15:0] hall_neg_data,
  input  wire logic        magnet_near_det,
  input  wire logic        magnet_close_det,
  // Inductive front end, channel two
  input  wire logic        chan2_valid,
  input  wire logic [7:0]  chan2_data,
  // Events from the rest of the engine
  input  wire logic        absorption_guard_active,
  input  wire logic        power_unit_event,
  input  wire logic        chip_level_event,
  input  wire logic        thermal_event,
  input  wire logic        discrete_button_event,
  input  wire logic        absorption_ui_event,
  // Configuration towards the front end
  output logic [7:0]       chan2_mode_cfg,
  output logic [7:0]       chan2_sense_cfg,
  output logic [7:0]       chan2_tuning_cfg,
  output logic [7:0]       chan2_extra_cfg,
  output logic             absorption_selected,
  // Dual-level results
  output logic             filter_halt,
  output logic             dual_near_level,
  output logic             dual_close_level
);
  // ****************************************
  // Storage
  // ****************************************
  logic        ack_q;
  logic [7:0]  rdata_q;
  logic [7:0]  mode_q, sense_q, tune_q, extra_q, ui_q;
  logic [7:0]  hyst_q, halt_thr_q, near_thr_q, contact_thr_q;
  logic [7:0]  events_q;
  logic        polarity_q, near_q, close_q;
  logic [15:0] amp_q;
  logic [7:0]  amp_hi_shadow_q;
  logic        halt_q;
  logic [1:0]  dual_prev_q;
  logic [1:0]  dual_lvl;
  logic [7:0]  dual_thr [2];
  logic [3:0]  dual_hyst [2];
  logic        access, wr, rd;
  logic        hyst_en;
  logic        magnet_hit;
  logic [7:0]  ev_set, ev_clr;
  logic [7:0]  rd_mux;

  assign access  = link.req && !ack_q;
  assign wr      = access && link.we;
  assign rd      = access && !link.we;
  assign hyst_en = ui_q[`HIF_UI_HYST_EN];

  // ****************************************
  // Link answer, one cycle after the request
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end

  always_comb begin
    case (link.addr)
      `HIF_A_EVENTS:      rd_mux = events_q;
      `HIF_A_MAG_FLAGS:   rd_mux = {5'h00, close_q, near_q,
                                    polarity_q};
      `HIF_A_MAG_AMP_LO:  rd_mux = amp_q[7:0];
      `HIF_A_MAG_AMP_HI:  rd_mux = amp_hi_shadow_q;
      `HIF_A_CHAN2_MODE:  rd_mux = mode_q;
      `HIF_A_CHAN2_SENSE: rd_mux = sense_q;
      `HIF_A_CHAN2_TUNE:  rd_mux = tune_q;
      `HIF_A_CHAN2_EXTRA: rd_mux = extra_q;
      `HIF_A_UI_ENABLE:   rd_mux = ui_q;
      `HIF_A_HYST_CFG:    rd_mux = hyst_q;
      `HIF_A_HALT_THR:    rd_mux = halt_thr_q;
      `HIF_A_NEAR_THR:    rd_mux = near_thr_q;
      `HIF_A_CONTACT_THR: rd_mux = contact_thr_q;
      default:            rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= `HIF_RST_BYTE;
    end else if (rd) begin
      rdata_q <= rd_mux;
    end
  end

  // ****************************************
  // Writable settings
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q        <= `HIF_RST_BYTE;
      sense_q       <= `HIF_RST_BYTE;
      tune_q        <= `HIF_RST_BYTE;
      extra_q       <= `HIF_RST_BYTE;
      ui_q          <= `HIF_RST_BYTE;
      hyst_q        <= `HIF_RST_BYTE;
      halt_thr_q    <= `HIF_RST_BYTE;
      near_thr_q    <= `HIF_RST_BYTE;
      contact_thr_q <= `HIF_RST_BYTE;
    end else if (wr) begin
      // Read-only results silently ignore writes
      case (link.addr)
        `HIF_A_CHAN2_MODE:  mode_q        <= link.wdata;
        `HIF_A_CHAN2_SENSE: sense_q       <= link.wdata;
        `HIF_A_CHAN2_TUNE:  tune_q        <= link.wdata;
        `HIF_A_CHAN2_EXTRA: extra_q       <= link.wdata;
        `HIF_A_UI_ENABLE:   ui_q          <= link.wdata;
        `HIF_A_HYST_CFG:    hyst_q        <= link.wdata;
        `HIF_A_HALT_THR:    halt_thr_q    <= link.wdata;
        `HIF_A_NEAR_THR:    near_thr_q    <= link.wdata;
        `HIF_A_CONTACT_THR: contact_thr_q <= link.wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Magnet result, differential channels
  // ****************************************
  assign magnet_hit = hall_valid
                      && ((magnet_near_det && !near_q)
                          || (magnet_close_det && !close_q));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      polarity_q <= 1'b0;
      near_q     <= 1'b0;
      close_q    <= 1'b0;
      amp_q      <= 16'h0000;
    end else if (hall_valid) begin
      polarity_q <= hall_neg_data > hall_pos_data;
      near_q     <= magnet_near_det;
      close_q    <= magnet_close_det;
      amp_q      <= (hall_pos_data >= hall_neg_data)
                    ? hall_pos_data - hall_neg_data
                    : hall_neg_data - hall_pos_data;
    end
  end

  // Low-byte read freezes the high byte so a later update cannot tear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_hi_shadow_q <= `HIF_RST_BYTE;
    end else if (rd && link.addr == `HIF_A_MAG_AMP_LO) begin
      amp_hi_shadow_q <= amp_q[15:8];
    end
  end

  // ****************************************
  // Dual-level interface on channel two
  // ****************************************
  assign dual_thr[0]  = near_thr_q;
  assign dual_thr[1]  = contact_thr_q;
  assign dual_hyst[0] = hyst_q[3:0];
  assign dual_hyst[1] = hyst_q[7:4];

  // Only the channel two sample path reaches the comparators
  for (genvar i = 0; i < 2; i++) begin : g_level
    hif_level_cmp u_cmp (
      .pclk         (pclk),
      .presetn      (presetn),
      .enable       (hyst_en),
      .sample_valid (chan2_valid),
      .sample       (chan2_data),
      .threshold    (dual_thr[i]),
      .hysteresis   (dual_hyst[i]),
      .level_q      (dual_lvl[i])
    );
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_q <= 1'b0;
    end else if (!hyst_en) begin
      halt_q <= 1'b0;
    end else if (chan2_valid) begin
      halt_q <= chan2_data >= halt_thr_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dual_prev_q <= 2'b00;
    end else begin
      dual_prev_q <= dual_lvl;
    end
  end

  // ****************************************
  // Event register
  // ****************************************
  // Button and absorption events share one selector so only one can report
  always_comb begin
    ev_set = 8'h00;
    ev_set[`HIF_EV_BUTTON] = discrete_button_event
                             && !ui_q[`HIF_UI_ABS_SEL];
    ev_set[`HIF_EV_ABS_UI] = absorption_ui_event
                             && ui_q[`HIF_UI_ABS_SEL];
    ev_set[`HIF_EV_DUAL_UI]  = dual_lvl != dual_prev_q;
    ev_set[`HIF_EV_THERMAL]  = thermal_event;
    ev_set[`HIF_EV_CHIP]     = chip_level_event;
    ev_set[`HIF_EV_POWER]    = power_unit_event;
    ev_clr = (rd && link.addr == `HIF_A_EVENTS) ? 8'hFF : 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events_q <= `HIF_RST_BYTE;
    end else begin
      // Set wins over read-clear so no event is lost
      events_q <= (events_q & ~ev_clr) | ev_set;
      events_q[`HIF_EV_MAGNET] <= events_q[`HIF_EV_MAGNET]
                                  ^ magnet_hit;
      events_q[`HIF_EV_GUARD]  <= absorption_guard_active;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.ack            = ack_q;
  assign link.rdata          = rdata_q;
  assign chan2_mode_cfg      = mode_q;
  assign chan2_sense_cfg     = sense_q;
  assign chan2_tuning_cfg    = tune_q;
  assign chan2_extra_cfg     = extra_q;
  assign absorption_selected = ui_q[`HIF_UI_ABS_SEL];
  assign filter_halt         = halt_q;
  assign dual_near_level     = dual_lvl[0];
  assign dual_close_level    = dual_lvl[1];
endmodule
`default_nettype wire

// [core/hif_host.sv]
// Host end: APB command registers driving the device register link
`timescale 1ns/1ps
`include "hif_consts.svh"
`default_nettype none
module hif_host (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Register link
  hif_link_if.host         link
);
  hif_pkg::hif_host_state_e state_q;
  logic        req_q, we_q;
  logic [7:0]  addr_q, wdata_q, rdata_q, ui_shadow_q;
  logic [2:0]  init_q;
  logic        refused_q;
  logic [31:0] prdata_q;
  logic        mapped, cmd_wr, refuse;
  logic [7:0]  init_addr, init_data;

  assign mapped = paddr == `HIF_APB_CMD || paddr == `HIF_APB_STATUS;
  assign cmd_wr = psel && penable && pwrite && paddr == `HIF_APB_CMD;
  // Settings of a disabled dual-level interface could upset live ones
  assign refuse = pwdata[16] && pwdata[7:6] == 2'b10
                  && !ui_shadow_q[`HIF_UI_HYST_EN];

  // ****************************************
  // Start-up sequence for channel two
  // ****************************************
  always_comb begin
    case (init_q)
      3'h0: begin
        init_addr = `HIF_A_CHAN2_MODE;
        init_data = `HIF_INIT_MODE;
      end
      3'h1: begin
        init_addr = `HIF_A_CHAN2_SENSE;
        init_data = `HIF_INIT_SENSE;
      end
      3'h2: begin
        init_addr = `HIF_A_CHAN2_TUNE;
        init_data = `HIF_INIT_TUNE;
      end
      default: begin
        init_addr = `HIF_A_UI_ENABLE;
        init_data = `HIF_INIT_UI;
      end
    endcase
  end

  // ****************************************
  // Link sequencer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= hif_pkg::HIF_IDLE;
      req_q       <= 1'b0;
      we_q        <= 1'b0;
      addr_q      <= `HIF_RST_BYTE;
      wdata_q     <= `HIF_RST_BYTE;
      rdata_q     <= `HIF_RST_BYTE;
      ui_shadow_q <= `HIF_RST_BYTE;
      init_q      <= 3'h0;
      refused_q   <= 1'b0;
    end else begin
      case (state_q)
        hif_pkg::HIF_IDLE: begin
          if (init_q != `HIF_INIT_STEPS) begin
            req_q   <= 1'b1;
            we_q    <= 1'b1;
            addr_q  <= init_addr;
            wdata_q <= init_data;
            init_q  <= init_q + 3'h1;
            state_q <= hif_pkg::HIF_WAIT;
          end else if (cmd_wr && refuse) begin
            refused_q <= 1'b1;
          end else if (cmd_wr) begin
            refused_q <= 1'b0;
            req_q     <= 1'b1;
            we_q      <= pwdata[16];
            addr_q    <= pwdata[7:0];
            wdata_q   <= pwdata[15:8];
            state_q   <= hif_pkg::HIF_WAIT;
          end
        end
        hif_pkg::HIF_WAIT: begin
          if (link.ack) begin
            req_q   <= 1'b0;
            state_q <= hif_pkg::HIF_IDLE;
            if (!we_q) begin
              rdata_q <= link.rdata;
            end else if (addr_q == `HIF_A_UI_ENABLE) begin
              ui_shadow_q <= wdata_q;
            end
          end
        end
        default: state_q <= hif_pkg::HIF_IDLE;
      endcase
    end
  end

  // ****************************************
  // APB read data, captured in the setup cycle
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      if (paddr == `HIF_APB_CMD) begin
        prdata_q <= {15'h0000, we_q, wdata_q, addr_q};
      end else if (paddr == `HIF_APB_STATUS) begin
        prdata_q <= {16'h0000, rdata_q, 5'h00, init_q != `HIF_INIT_STEPS,
                     refused_q, state_q == hif_pkg::HIF_WAIT};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  assign prdata     = prdata_q;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !mapped;
  assign link.req   = req_q;
  assign link.we    = we_q;
  assign link.addr  = addr_q;
  assign link.wdata = wdata_q;
endmodule
`default_nettype wire

// [core/hif_level_cmp.sv]
// Threshold comparator with release hysteresis for one level output
`timescale 1ns/1ps
`default_nettype none
module hif_level_cmp (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Sample and settings
  input  wire logic       enable,
  input  wire logic       sample_valid,
  input  wire logic [7:0] sample,
  input  wire logic [7:0] threshold,
  input  wire logic [3:0] hysteresis,
  // Result
  output logic            level_q
);
  logic [8:0] release_lvl;

  // A band wider than the threshold never releases instead of wrapping
  assign release_lvl = {1'b0, threshold} - {5'h00, hysteresis};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
    end else if (!enable) begin
      level_q <= 1'b0;
    end else if (sample_valid) begin
      if (!level_q && sample >= threshold) begin
        level_q <= 1'b1;
      end else if (level_q && !release_lvl[8]
                   && sample < release_lvl[7:0]) begin
        level_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [core/hif_link_if.sv]
// Register link between host controller and sensor device
`timescale 1ns/1ps
`default_nettype none
interface hif_link_if;
  logic       req;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  modport device (input req, input we, input addr, input wdata,
                  output ack, output rdata);
  modport host (output req, output we, output addr, output wdata,
                input ack, input rdata);
endinterface
`default_nettype wire

// [core/hif_pkg.sv]
// Shared types for the sensor result block
package hif_pkg;
  typedef enum logic [0:0] {
    HIF_IDLE = 1'b0,
    HIF_WAIT = 1'b1
  } hif_host_state_e;
endpackage

// [testbench/hall_inductive_result_flags_tb.sv]
// Self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
`default_nettype none
module hall_inductive_result_flags_tb;
  typedef struct {logic [32:0] v; logic [32:0] m;} hif_note_s;
  localparam logic [7:0] SMP [8] = '{8'h40, 8'h3D, 8'h3C, 8'h60,
                                     8'h5E, 8'h5D, 8'h90, 8'h8F};
  localparam logic [2:0] LVL [8] = '{3'h1, 3'h1, 3'h0, 3'h3,
                                     3'h3, 3'h1, 3'h7, 3'h3};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hall_valid = 1'b0;
  logic [15:0] hall_pos = 16'h0;
  logic [15:0] hall_neg = 16'h0;
  logic        near_det = 1'b0;
  logic        close_det = 1'b0;
  logic        chan2_valid = 1'b0;
  logic [7:0]  chan2_data = 8'h00;
  logic        guard = 1'b0;
  logic [4:0]  ev = 5'h00;
  logic [7:0]  cfg_mode, cfg_sense, cfg_tune, cfg_extra;
  logic        abs_sel, halt, d_near, d_close;
  int          mismatches = 0;
  int          num_checks = 0;
  int          seed = 32'h86f628a5;
  logic        want = 1'b0;
  hif_note_s   notes[$];
  hif_note_s   nt;
  logic        tog = 1'b0, pn = 1'b0, pc = 1'b0;
  logic [7:0]  flg, hi, d;
  logic [15:0] amp;
  logic [31:0] r;

  always #12.5 pclk = ~pclk;

  hif_link_if u_link ();
  hif_host u_hif_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(u_link));
  hif_device u_hif_device (.pclk(pclk), .presetn(presetn), .link(u_link),
    .hall_valid(hall_valid), .hall_pos_data(hall_pos),
    .hall_neg_data(hall_neg), .magnet_near_det(near_det),
    .magnet_close_det(close_det), .chan2_valid(chan2_valid),
    .chan2_data(chan2_data), .absorption_guard_active(guard),
    .power_unit_event(ev[4]), .chip_level_event(ev[3]),
    .thermal_event(ev[2]), .absorption_ui_event(ev[1]),
    .discrete_button_event(ev[0]), .chan2_mode_cfg(cfg_mode),
    .chan2_sense_cfg(cfg_sense), .chan2_tuning_cfg(cfg_tune),
    .chan2_extra_cfg(cfg_extra), .absorption_selected(abs_sel),
    .filter_halt(halt), .dual_near_level(d_near),
    .dual_close_level(d_close));
  hif_link_monitor u_hif_link_monitor (.pclk(pclk), .presetn(presetn),
    .req(u_link.req), .we(u_link.we), .addr(u_link.addr),
    .wdata(u_link.wdata), .ack(u_link.ack), .rdata(u_link.rdata));

  // ****************************************
  // Compare tasks and result watcher
  // ****************************************
  task automatic cmp_word(input logic [32:0] e, input logic [32:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value apb read exp %h seen %h", e, s);
    end
  endtask
  task automatic cmp_port(input string nm, input logic [7:0] e,
                          input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Only reads that carry a note are judged; status polls are not
  always @(posedge pclk) begin
    if (want && psel && penable && pready && !pwrite && notes.size() > 0) begin
      nt = notes.pop_front();
      cmp_word(nt.v & nt.m, {pslverr, prdata} & nt.m);
    end
  end

  // ****************************************
  // Drivers
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, input logic k);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    want <= k;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait limit here: a slave that never answers trips the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    want <= 1'b0;
  endtask
  task automatic chk_apb(input logic [11:0] a, input logic [32:0] v,
                         input logic [32:0] m);
    notes.push_back('{v, m});
    apb(1'b0, a, 32'h0, 1'b1);
  endtask
  task automatic idle();
    do begin
      apb(1'b0, 12'h004, 32'h0, 1'b0);
    end while (r[2] !== 1'b0 || r[0] !== 1'b0);
  endtask
  task automatic lnk(input logic w, input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, 12'h000, {15'h0, w, v, a}, 1'b0);
    idle();
  endtask
  task automatic lrd(input logic [7:0] a, input logic [7:0] e);
    lnk(1'b0, a, 8'h00);
    chk_apb(12'h004, {17'h0, e, 8'h00}, 33'h1_0000_FF07);
  endtask
  task automatic hall(input logic nr, input logic cl);
    logic [15:0] hp, hn;
    hp = 16'($random(seed));
    hn = 16'($random(seed));
    @(posedge pclk);
    hall_valid <= 1'b1;
    hall_pos <= hp;
    hall_neg <= hn;
    near_det <= nr;
    close_det <= cl;
    @(posedge pclk);
    hall_valid <= 1'b0;
    amp = (hn > hp) ? hn - hp : hp - hn;
    flg = {5'h0, cl, nr, hn > hp};
    tog = tog ^ ((nr & !pn) | (cl & !pc));
    pn = nr;
    pc = cl;
  endtask
  task automatic chan2(input logic [7:0] s, input logic [2:0] e);
    @(posedge pclk);
    chan2_valid <= 1'b1;
    chan2_data <= s;
    @(posedge pclk);
    chan2_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    cmp_port("dual levels", {5'h0, e}, {5'h0, halt, d_close, d_near});
  endtask
  task automatic pulse(input logic [4:0] v);
    @(posedge pclk);
    ev <= v;
    @(posedge pclk);
    ev <= 5'h00;
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    idle();
    lrd(8'h42, 8'h0E);
    lrd(8'h45, 8'h03);
    lrd(8'h48, 8'h82);
    lrd(8'h50, 8'h01);
    cmp_port("mode cfg", 8'h0E, cfg_mode);
    cmp_port("tuning cfg", 8'h82, cfg_tune);
    cmp_port("sense cfg", 8'h03, cfg_sense);
    d = 8'($random(seed));
    lnk(1'b1, 8'h4B, d);
    lrd(8'h4B, d);
    cmp_port("extra cfg", d, cfg_extra);
    chk_apb(12'h008, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
    lnk(1'b1, 8'h11, 8'hFF);
    lrd(8'h20, 8'h00);
    hall(1'b1, 1'b0);
    lrd(8'h11, {5'h0, tog, 2'b00});
    lrd(8'h16, flg);
    lrd(8'h17, amp[7:0]);
    hi = amp[15:8];
    hall(1'b1, 1'b1);
    lrd(8'h18, hi);
    lrd(8'h16, flg);
    lrd(8'h17, amp[7:0]);
    lrd(8'h18, amp[15:8]);
    hall(1'b0, 1'b0);
    lrd(8'h16, flg);
    lnk(1'b1, 8'h80, 8'h23);
    lnk(1'b1, 8'h81, 8'h90);
    lnk(1'b1, 8'h82, 8'h40);
    lnk(1'b1, 8'h83, 8'h60);
    for (int i = 0; i < 8; i++)
      chan2(SMP[i], LVL[i]);
    lnk(1'b1, 8'h50, 8'h00);
    chan2(8'h70, 3'h0);
    lnk(1'b1, 8'h82, 8'h11);
    chk_apb(12'h004, 33'h2, 33'h2);
    lnk(1'b1, 8'h50, 8'h01);
    lrd(8'h82, 8'h40);
    lnk(1'b0, 8'h11, 8'h00);
    chk_apb(12'h004, {22'h0, tog, 10'h0}, 33'h400);
    guard <= 1'b1;
    pulse(5'h1F);
    lrd(8'h11, {4'hF, 1'b0, tog, 2'b01});
    lrd(8'h11, {1'b1, 4'h0, tog, 2'b00});
    guard <= 1'b0;
    lnk(1'b1, 8'h50, 8'h03);
    cmp_port("absorption select", 8'h01, {7'h0, abs_sel});
    chan2(8'h70, 3'h3);
    pulse(5'h03);
    lrd(8'h11, {4'h0, 1'b1, tog, 2'b10});
    wrap_up();
  end
  // Far beyond the few hundred cycles the scenarios need
  initial begin
    #(25 * 20000);
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire

// [testbench/hif_link_monitor.sv]
// Link protocol and register checker for the sensor result block
`timescale 1ns/1ps
`default_nettype none
module hif_link_monitor (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Link signals
  input  wire logic       req,
  input  wire logic       we,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       ack,
  input  wire logic [7:0] rdata
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic [7:0] mir_q [256];
  logic       rw_w;
  logic       map_w;
  assign rw_w = addr inside {8'h42, 8'h45, 8'h48, 8'h4B, 8'h50,
                             [8'h80:8'h83]};
  assign map_w = rw_w || (addr inside {8'h11, [8'h16:8'h18]});
  // Mirror of link writes; zero reset matches the device
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 256; i++)
        mir_q[i] <= 8'h00;
    end else if (ack && we && rw_w) begin
      mir_q[addr] <= wdata;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ack_pulse: assert property (ack |=> !ack)
    else $error("link ack longer than one cycle");
  chk_ack_latency: assert property (req && !ack |=> ack)
    else $error("link ack missing one cycle after request");
  chk_ack_cause: assert property (ack |-> $past(req))
    else $error("link ack without request");
  chk_req_hold: assert property (req && !ack |=> req
    && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("link request changed before ack");
  chk_req_release: assert property (ack |=> !req)
    else $error("link request not dropped after ack");
  chk_rdata_hold: assert property ($changed(rdata) |-> ack && !we)
    else $error("link read data moved outside a read ack");
  chk_flags_unused: assert property (ack && !we && addr == 8'h16
    |-> rdata[7:3] == 5'h00)
    else $error("magnet flags unused bits set");
  chk_unmapped_zero: assert property (ack && !we && !map_w
    |-> rdata == 8'h00)
    else $error("unmapped offset read not zero");
  chk_cfg_readback: assert property (ack && !we && rw_w
    |-> rdata == mir_q[addr])
    else $error("config register read differs from last write");
endmodule
`default_nettype wire
